// File: ccsl_cfg.svh
// Purpose: addresses, field positions, reset values and timing counts of the clock control block
// Assumes: 200 MHz system clock, oscillators delivered as one-cycle tick enables
// Notes: definitions only
`ifndef CCSL_CFG_SVH
`define CCSL_CFG_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define CCSL_OFS_CPUSRC 9'h030
`define CCSL_OFS_TMRCFG 9'h031
`define CCSL_OFS_CLKIO 9'h032
`define CCSL_OFS_FTRIM 9'h034
`define CCSL_OFS_STRIM 9'h036
`define CCSL_OFS_OSC0 9'h1E0
`define CCSL_OFS_DUTY 9'h1E2
`define CCSL_OFS_STAT 9'h1E3

// ----------------------------------------------------------------
// reset values and writable-bit masks
// ----------------------------------------------------------------
`define CCSL_RST_CPUSRC 8'h00
`define CCSL_RST_TMRCFG 8'h8F
`define CCSL_RST_CLKIO 8'h00
`define CCSL_RST_OSC0 8'h00
`define CCSL_RST_DUTY 8'h00
`define CCSL_MSK_CPUSRC 8'h01
`define CCSL_MSK_TMRCFG 8'hFF
`define CCSL_MSK_CLKIO 8'h0F
`define CCSL_MSK_OSC0 8'h3F
`define CCSL_MSK_DUTY 8'h07

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CCSL_CPUSRC_SEL 0
`define CCSL_OSC0_SPD_LSB 0
`define CCSL_OSC0_SPD_MSB 2
`define CCSL_OSC0_SLP_LSB 3
`define CCSL_OSC0_SLP_MSB 4
`define CCSL_OSC0_NOBUZZ 5
`define CCSL_CLKIO_OSEL_LSB 0
`define CCSL_CLKIO_OSEL_MSB 1
`define CCSL_CLKIO_BYPASS 2
`define CCSL_CLKIO_XTAL 3
`define CCSL_TMR_ISEL_LSB 0
`define CCSL_TMR_ISEL_MSB 1
`define CCSL_TMR_IDIV_LSB 2
`define CCSL_TMR_IDIV_MSB 3
`define CCSL_TMR_CSEL_LSB 4
`define CCSL_TMR_CSEL_MSB 5
`define CCSL_TMR_CDIV_LSB 6
`define CCSL_TMR_CDIV_MSB 7
`define CCSL_DUTY_LSB 0
`define CCSL_DUTY_MSB 1
`define CCSL_DUTY_NORMAL 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CCSL_CLK_MHZ 200
`define CCSL_FILTER_NS 20
`define CCSL_FILTER_CYC ((`CCSL_FILTER_NS * `CCSL_CLK_MHZ + 999) / 1000)
`define CCSL_SLOW_HZ 32768
`define CCSL_SLEEP_TICKS_0 (`CCSL_SLOW_HZ / 512)
`define CCSL_SLEEP_TICKS_1 (`CCSL_SLOW_HZ / 64)
`define CCSL_SLEEP_TICKS_2 (`CCSL_SLOW_HZ / 8)
`define CCSL_SLEEP_TICKS_3 (`CCSL_SLOW_HZ / 1)
`define CCSL_WDT_PERIODS 3
`define CCSL_DUTY_TICKS_0 256
`define CCSL_DUTY_TICKS_1 1024
`define CCSL_DUTY_TICKS_2 64
`define CCSL_DUTY_TICKS_3 16
`define CCSL_DUTY_ON_TICKS 1

`endif

// File: ccsl_pkg.sv
// Purpose: shared types of the clock control block
// Assumes: nothing
// Notes: encodings follow the select fields
package ccsl_pkg;
    typedef enum logic [1:0] {
        CCSL_OUT_FAST,
        CCSL_OUT_EXT,
        CCSL_OUT_SLOW,
        CCSL_OUT_CPU
    } ccsl_outsrc_e;
    typedef logic [7:0] ccsl_byte_t;
endpackage

// File: ccsl_tick_div.sv
// Purpose: divides a tick enable by a divisor taken only at a period boundary
// Assumes: tickIn is a one-cycle pulse; divisor >= 1
// Notes: new divisor applied at the output pulse, so no short period appears
`timescale 1ns/1ps
module ccsl_tick_div #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_DIV = W'(1)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tickIn,
    input wire logic [W-1:0] divisor,
    output logic tickOut
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] div_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            div_r <= RST_DIV;
            tickOut <= 1'b0;
        end else begin
            tickOut <= 1'b0;
            if (tickIn) begin
                if (cnt_r >= div_r - W'(1)) begin
                    cnt_r <= '0;
                    div_r <= divisor;
                    tickOut <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + W'(1);
                end
            end
        end
    end
endmodule

// File: ccsl_clock_ctrl.sv
// Purpose: clock source selection, dividers, sleep/watchdog timing and detector duty control
// Assumes: oscillators arrive as tick enables, pins synchronous to clk
// Notes: every clock is a one-cycle enable; the clock output pin pulses once per source tick
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "ccsl_cfg.svh"

// Overview of operation
// - processor, interval and capture timer clocks each select their own source.
// - source bit 0 picks fast oscillator, 1 picks external; resets to 0.
// - external source is crystal when enabled, otherwise the input pin.
// - external path passes a glitch filter that software can bypass.
// - speed code 000 divides by 8, 001 by 4, 010 by 2.
// - speed field resets to zero: 3 MHz from fast oscillator.
// - sleep field sets 512, 64, 8 or 1 Hz sleep clock.
// - watchdog period follows sleep setting, about three sleep periods.
// - detector cleared continuous bit: enabled periodically during sleep by duty setting.
// - continuous bit set: detector always enabled during sleep.
// - detector duty cycling runs independent of sleep interval.
// - clock output pin drivable from four sources when crystal absent.
// - slow oscillator keeps running in suspend and times wake-ups.
// - slow oscillator selectable for interval and capture timer clocks.
// - slow oscillator has low-power and normal modes.
// - power-on loads 3.30V fast trim; firmware rewrites trims later.
// - output select 00 fast, 01 external, 10 slow, 11 processor.
// - bypass bit set routes external input around the filter.
// - crystal enabled disables the two shared general-purpose drivers.
module ccsl_clock_ctrl
    import ccsl_pkg::*;
#(
    parameter ccsl_byte_t FAST_TRIM_3V30 = 8'h10,
    parameter ccsl_byte_t SLOW_TRIM_3V30 = 8'h10
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [8:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic fastOscTick,
    input wire logic slowOscTick,
    input wire logic xtalClkIn,
    input wire logic extClkPin,
    input wire logic sleepMode,
    input wire logic wdtClear,
    output logic processorClkTick,
    output logic intervalTimerTick,
    output logic captureTimerTick,
    output logic sleepWake,
    output logic wdtExpire,
    output logic detectEnable,
    output logic clockOutPinO,
    output logic clockOutPinOeN,
    output logic sharedGpioOff,
    output logic crystalOscEnable,
    output logic slowOscNormalMode,
    output logic [7:0] fastOscTrim,
    output logic [7:0] slowOscTrim
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    ccsl_byte_t cpuSrc_r;
    ccsl_byte_t tmrCfg_r;
    ccsl_byte_t clkIo_r;
    ccsl_byte_t osc0_r;
    ccsl_byte_t duty_r;
    ccsl_byte_t fastTrim_r;
    ccsl_byte_t slowTrim_r;
    ccsl_byte_t rdData_nxt;
    logic xtalEn;
    logic filterBypass;
    logic noBuzz;
    ccsl_outsrc_e outSel;

    assign xtalEn = clkIo_r[`CCSL_CLKIO_XTAL];
    assign filterBypass = clkIo_r[`CCSL_CLKIO_BYPASS];
    assign noBuzz = osc0_r[`CCSL_OSC0_NOBUZZ];
    assign outSel = ccsl_outsrc_e'(clkIo_r[`CCSL_CLKIO_OSEL_MSB:`CCSL_CLKIO_OSEL_LSB]);

    // source and speed reset to zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpuSrc_r <= `CCSL_RST_CPUSRC;
            tmrCfg_r <= `CCSL_RST_TMRCFG;
            clkIo_r <= `CCSL_RST_CLKIO;
            osc0_r <= `CCSL_RST_OSC0;
            duty_r <= `CCSL_RST_DUTY;
        end else if (regWrStb) begin
            unique case (regAddr)
                `CCSL_OFS_CPUSRC: cpuSrc_r <= regWrData & `CCSL_MSK_CPUSRC;
                `CCSL_OFS_TMRCFG: tmrCfg_r <= regWrData & `CCSL_MSK_TMRCFG;
                `CCSL_OFS_CLKIO: clkIo_r <= regWrData & `CCSL_MSK_CLKIO;
                `CCSL_OFS_OSC0: osc0_r <= regWrData & `CCSL_MSK_OSC0;
                `CCSL_OFS_DUTY: duty_r <= regWrData & `CCSL_MSK_DUTY;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fastTrim_r <= FAST_TRIM_3V30;
            slowTrim_r <= SLOW_TRIM_3V30;
        end else if (regWrStb) begin
            if (regAddr == `CCSL_OFS_FTRIM) begin
                fastTrim_r <= regWrData;
            end
            if (regAddr == `CCSL_OFS_STRIM) begin
                slowTrim_r <= regWrData;
            end
        end
    end

    // ------------------------------------------------------------
    // external clock path
    // ------------------------------------------------------------
    logic extRaw;
    logic extFilt_r;
    logic extPrev_r;
    logic extTick;
    logic [7:0] stab_r;

    assign extRaw = xtalEn ? xtalClkIn : extClkPin;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            extFilt_r <= 1'b0;
            stab_r <= '0;
        end else if (extRaw == extFilt_r) begin
            stab_r <= '0;
        end else if (filterBypass || stab_r >= 8'(`CCSL_FILTER_CYC - 1)) begin
            extFilt_r <= extRaw;
            stab_r <= '0;
        end else begin
            stab_r <= stab_r + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            extPrev_r <= 1'b0;
        end else begin
            extPrev_r <= extFilt_r;
        end
    end
    assign extTick = extFilt_r & ~extPrev_r;

    function automatic logic pickTick(input logic [1:0] sel, input logic alt);
        unique case (sel)
            2'b00: pickTick = fastOscTick;
            2'b01: pickTick = extTick;
            2'b10: pickTick = slowOscTick;
            2'b11: pickTick = alt;
        endcase
    endfunction

    // ------------------------------------------------------------
    // processor clock
    // ------------------------------------------------------------
    logic srcApplied_r;
    logic cpuSrcTick;
    logic [7:0] cpuDiv;

    always_comb begin
        unique case (osc0_r[`CCSL_OSC0_SPD_MSB:`CCSL_OSC0_SPD_LSB])
            3'b001: cpuDiv = 8'h04;
            3'b010: cpuDiv = 8'h02;
            3'b100: cpuDiv = 8'h10;
            3'b101: cpuDiv = 8'h20;
            3'b110: cpuDiv = 8'h80;
            default: cpuDiv = 8'h08;
        endcase
    end

    assign cpuSrcTick = srcApplied_r ? extTick : fastOscTick;

    // source taken only at a period boundary
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            srcApplied_r <= 1'b0;
        end else if (processorClkTick) begin
            srcApplied_r <= cpuSrc_r[`CCSL_CPUSRC_SEL];
        end
    end

    // divisor taken only at a period boundary
    ccsl_tick_div #(.W(8), .RST_DIV(8'h08)) uCpuDiv (
        .clk(clk),
        .nrst(nrst),
        .tickIn(cpuSrcTick),
        .divisor(cpuDiv),
        .tickOut(processorClkTick)
    );

    // ------------------------------------------------------------
    // timer clocks
    // ------------------------------------------------------------
    logic capSrcTick;
    logic itvSrcTick;
    logic [3:0] capDiv;
    logic [2:0] itvDiv;

    always_comb begin
        capSrcTick = pickTick(tmrCfg_r[`CCSL_TMR_CSEL_MSB:`CCSL_TMR_CSEL_LSB], 1'b0);
        itvSrcTick = pickTick(tmrCfg_r[`CCSL_TMR_ISEL_MSB:`CCSL_TMR_ISEL_LSB], captureTimerTick);
    end
    assign capDiv = {1'b0, tmrCfg_r[`CCSL_TMR_CDIV_MSB:`CCSL_TMR_CDIV_LSB], 1'b0} + 4'h2;
    assign itvDiv = {1'b0, tmrCfg_r[`CCSL_TMR_IDIV_MSB:`CCSL_TMR_IDIV_LSB]} + 3'h1;

    ccsl_tick_div #(.W(4), .RST_DIV(4'h6)) uCapDiv (
        .clk(clk),
        .nrst(nrst),
        .tickIn(capSrcTick),
        .divisor(capDiv),
        .tickOut(captureTimerTick)
    );

    ccsl_tick_div #(.W(3), .RST_DIV(3'h4)) uItvDiv (
        .clk(clk),
        .nrst(nrst),
        .tickIn(itvSrcTick),
        .divisor(itvDiv),
        .tickOut(intervalTimerTick)
    );

    // ------------------------------------------------------------
    // sleep timer and watchdog
    // ------------------------------------------------------------
    logic [15:0] sleepCnt_r;
    logic [15:0] sleepPer;
    logic [1:0] wdtCnt_r;

    always_comb begin
        unique case (osc0_r[`CCSL_OSC0_SLP_MSB:`CCSL_OSC0_SLP_LSB])
            2'b00: sleepPer = 16'(`CCSL_SLEEP_TICKS_0);
            2'b01: sleepPer = 16'(`CCSL_SLEEP_TICKS_1);
            2'b10: sleepPer = 16'(`CCSL_SLEEP_TICKS_2);
            2'b11: sleepPer = 16'(`CCSL_SLEEP_TICKS_3);
        endcase
    end

    // counts slow ticks in any mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleepCnt_r <= '0;
            sleepWake <= 1'b0;
        end else begin
            sleepWake <= 1'b0;
            if (slowOscTick) begin
                if (sleepCnt_r >= sleepPer - 16'h0001) begin
                    sleepCnt_r <= '0;
                    sleepWake <= 1'b1;
                end else begin
                    sleepCnt_r <= sleepCnt_r + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wdtCnt_r <= '0;
            wdtExpire <= 1'b0;
        end else begin
            wdtExpire <= 1'b0;
            if (wdtClear) begin
                wdtCnt_r <= '0;
            end else if (sleepWake) begin
                if (wdtCnt_r == 2'(`CCSL_WDT_PERIODS - 1)) begin
                    wdtCnt_r <= '0;
                    wdtExpire <= 1'b1;
                end else begin
                    wdtCnt_r <= wdtCnt_r + 2'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // supply detector duty cycle
    // ------------------------------------------------------------
    logic [10:0] dutyCnt_r;
    logic [10:0] dutyPer;
    logic dutyOn;

    always_comb begin
        unique case (duty_r[`CCSL_DUTY_MSB:`CCSL_DUTY_LSB])
            2'b00: dutyPer = 11'(`CCSL_DUTY_TICKS_0);
            2'b01: dutyPer = 11'(`CCSL_DUTY_TICKS_1);
            2'b10: dutyPer = 11'(`CCSL_DUTY_TICKS_2);
            2'b11: dutyPer = 11'(`CCSL_DUTY_TICKS_3);
        endcase
    end

    // own counter, free of sleep field
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dutyCnt_r <= '0;
        end else if (slowOscTick) begin
            if (dutyCnt_r >= dutyPer - 11'h001) begin
                dutyCnt_r <= '0;
            end else begin
                dutyCnt_r <= dutyCnt_r + 11'h001;
            end
        end
    end
    assign dutyOn = dutyCnt_r < 11'(`CCSL_DUTY_ON_TICKS);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            detectEnable <= 1'b1;
        end else begin
            detectEnable <= !sleepMode || noBuzz || dutyOn;
        end
    end

    // ------------------------------------------------------------
    // pins and oscillator controls
    // ------------------------------------------------------------
    // output pin and shared drivers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clockOutPinO <= 1'b0;
            clockOutPinOeN <= 1'b1;
            sharedGpioOff <= 1'b0;
            crystalOscEnable <= 1'b0;
            slowOscNormalMode <= 1'b0;
            fastOscTrim <= FAST_TRIM_3V30;
            slowOscTrim <= SLOW_TRIM_3V30;
        end else begin
            clockOutPinO <= pickTick(outSel, processorClkTick);
            clockOutPinOeN <= xtalEn;
            sharedGpioOff <= xtalEn;
            crystalOscEnable <= xtalEn;
            slowOscNormalMode <= duty_r[`CCSL_DUTY_NORMAL];
            fastOscTrim <= fastTrim_r;
            slowOscTrim <= slowTrim_r;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb begin
        unique case (regAddr)
            `CCSL_OFS_CPUSRC: rdData_nxt = cpuSrc_r;
            `CCSL_OFS_TMRCFG: rdData_nxt = tmrCfg_r;
            `CCSL_OFS_CLKIO: rdData_nxt = clkIo_r;
            `CCSL_OFS_FTRIM: rdData_nxt = fastTrim_r;
            `CCSL_OFS_STRIM: rdData_nxt = slowTrim_r;
            `CCSL_OFS_OSC0: rdData_nxt = osc0_r;
            `CCSL_OFS_DUTY: rdData_nxt = duty_r;
            `CCSL_OFS_STAT: rdData_nxt = {6'h00, extFilt_r, srcApplied_r};
            default: rdData_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRdStb ? rdData_nxt : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    src_read_a: assert property (@(posedge clk) disable iff (!nrst)
        regRdStb && regAddr == `CCSL_OFS_CPUSRC |=> regRdData == {7'h00, cpuSrc_r[0]})
        else $error("source register read mismatch");
    speed_write_a: assert property (@(posedge clk) disable iff (!nrst)
        regWrStb && regAddr == `CCSL_OFS_OSC0 |=> osc0_r[2:0] == $past(regWrData[2:0]))
        else $error("speed field not stored");
    bypass_path_a: assert property (@(posedge clk) disable iff (!nrst)
        filterBypass |=> extFilt_r == $past(extRaw))
        else $error("bypassed input not passed through");
    src_switch_a: assert property (@(posedge clk) disable iff (!nrst)
        $changed(srcApplied_r) |-> $past(processorClkTick))
        else $error("source switched mid period");
    nobuzz_on_a: assert property (@(posedge clk) disable iff (!nrst)
        sleepMode && noBuzz |=> detectEnable)
        else $error("detector off with continuous bit");
    duty_off_a: assert property (@(posedge clk) disable iff (!nrst)
        sleepMode && !noBuzz && !dutyOn |=> !detectEnable)
        else $error("detector on outside duty window");
    xtal_pins_a: assert property (@(posedge clk) disable iff (!nrst)
        xtalEn |=> sharedGpioOff && clockOutPinOeN)
        else $error("shared drivers active with crystal");
    out_fast_a: assert property (@(posedge clk) disable iff (!nrst)
        outSel == CCSL_OUT_FAST |=> clockOutPinO == $past(fastOscTick))
        else $error("output pin not following fast oscillator");
    trim_write_a: assert property (@(posedge clk) disable iff (!nrst)
        regWrStb && regAddr == `CCSL_OFS_FTRIM |=> ##1 fastOscTrim == $past(regWrData, 2))
        else $error("fast trim not updated");
endmodule

// File: ccsl_clock_source.sv
// Purpose: far-side model of oscillators, crystal and clock input pin
// Assumes: every source is seen synchronous to clk
// Notes: glitch makes the pin toggle faster than the filter window
`timescale 1ns/1ps
module ccsl_clock_source #(
    parameter int FAST_P = 4,
    parameter int SLOW_P = 10,
    parameter int EXT_HALF = 8,
    parameter int XTAL_HALF = 12
) (
    input wire logic clk,
    input wire logic glitch,
    output logic fastOscTick,
    output logic slowOscTick,
    output logic extClkPin,
    output logic xtalClkIn
);
    int fc = 0;
    int sc = 0;
    int ec = 0;
    int xc = 0;
    initial begin
        fastOscTick = 1'b0;
        slowOscTick = 1'b0;
        extClkPin = 1'b0;
        xtalClkIn = 1'b0;
    end
    always @(posedge clk) begin
        fc <= (fc == FAST_P - 1) ? 0 : fc + 1;
        fastOscTick <= (fc == FAST_P - 1);
        sc <= (sc == SLOW_P - 1) ? 0 : sc + 1;
        slowOscTick <= (sc == SLOW_P - 1);
        ec <= (ec >= (glitch ? 1 : EXT_HALF - 1)) ? 0 : ec + 1;
        if (ec >= (glitch ? 1 : EXT_HALF - 1)) begin
            extClkPin <= !extClkPin;
        end
        xc <= (xc == XTAL_HALF - 1) ? 0 : xc + 1;
        if (xc == XTAL_HALF - 1) begin
            xtalClkIn <= !xtalClkIn;
        end
    end
endmodule

// File: ccsl_clock_ctrl_tb.sv
// Purpose: self-checking bench of the clock control block
// Assumes: fast tick every 4 cycles, slow every 10, pin half 8, crystal half 12
// Notes: table rows first, then reset and awkward cases
`timescale 1ns/1ps
module ccsl_clock_ctrl_tb;
    import ccsl_pkg::*;
    typedef struct {logic [8:0] a; logic [7:0] d; int mon; logic gl; int e;} ccsl_row_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [8:0] regAddr = 9'h000;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic sleepMode = 1'b0;
    logic wdtClear = 1'b0;
    logic glitchOn = 1'b0;
    logic [7:0] regRdData, fastOscTrim, slowOscTrim;
    logic fastOscTick, slowOscTick, xtalClkIn, extClkPin, processorClkTick, intervalTimerTick;
    logic sleepWake, wdtExpire, detectEnable, clockOutPinO, clockOutPinOeN, sharedGpioOff, pulse;
    logic captureTimerTick, crystalOscEnable, slowOscNormalMode;
    int badCount = 0;
    int nChecks = 0;
    int cyc = 0;
    int mon = 0;
    int g, n;
    logic [7:0] v, u;
    ccsl_row_s rows [24] = '{
        '{9'h030, 8'hFE, 0, 1'b0, 'h00},
        '{9'h032, 8'hFF, 0, 1'b0, 'h0F},
        '{9'h1E0, 8'hFF, 0, 1'b0, 'h3F},
        '{9'h1E2, 8'hFF, 0, 1'b0, 'h07},
        '{9'h031, 8'hA5, 0, 1'b0, 'hA5},
        '{9'h034, 8'h3C, 0, 1'b0, 'h3C},
        '{9'h036, 8'hC3, 0, 1'b0, 'hC3},
        '{9'h1FF, 8'h55, 0, 1'b0, 'h00},
        '{9'h032, 8'h00, 2, 1'b0, 4},
        '{9'h032, 8'h02, 2, 1'b0, 10},
        '{9'h1E0, 8'h00, 1, 1'b0, 32},
        '{9'h1E0, 8'h01, 1, 1'b0, 16},
        '{9'h1E0, 8'h02, 1, 1'b0, 8},
        '{9'h030, 8'h01, 1, 1'b0, 32},
        '{9'h032, 8'h03, 2, 1'b0, 32},
        '{9'h032, 8'h01, 2, 1'b0, 16},
        '{9'h032, 8'h09, 1, 1'b0, 48},
        '{9'h030, 8'hFE, 1, 1'b0, 8},
        '{9'h032, 8'h01, 2, 1'b1, 0},
        '{9'h032, 8'h05, 2, 1'b1, 4},
        '{9'h031, 8'h04, 3, 1'b0, 8},
        '{9'h031, 8'h23, 3, 1'b0, 20},
        '{9'h031, 8'h40, 5, 1'b0, 16},
        '{9'h1E0, 8'h00, 4, 1'b0, 640}
    };
    always #2.5 clk = !clk;
    always_comb begin
        case (mon)
            1: pulse = processorClkTick;
            2: pulse = clockOutPinO;
            3: pulse = intervalTimerTick;
            4: pulse = sleepWake;
            5: pulse = captureTimerTick;
            default: pulse = 1'b0;
        endcase
    end
    ccsl_clock_source ccsl_clock_source_inst (.clk(clk), .glitch(glitchOn), .fastOscTick(fastOscTick),
        .slowOscTick(slowOscTick), .extClkPin(extClkPin), .xtalClkIn(xtalClkIn));
    ccsl_clock_ctrl ccsl_clock_ctrl_inst (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .fastOscTick(fastOscTick),
        .slowOscTick(slowOscTick), .xtalClkIn(xtalClkIn), .extClkPin(extClkPin), .sleepMode(sleepMode),
        .wdtClear(wdtClear), .processorClkTick(processorClkTick), .intervalTimerTick(intervalTimerTick),
        .captureTimerTick(captureTimerTick), .sleepWake(sleepWake), .wdtExpire(wdtExpire),
        .detectEnable(detectEnable),
        .clockOutPinO(clockOutPinO), .clockOutPinOeN(clockOutPinOeN), .sharedGpioOff(sharedGpioOff),
        .crystalOscEnable(crystalOscEnable), .slowOscNormalMode(slowOscNormalMode), .fastOscTrim(fastOscTrim),
        .slowOscTrim(slowOscTrim));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task stopTest;
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chkVal(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chkCnt(input int got, input int exp);
        nChecks++;
        if (got != exp) begin
            badCount++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
    endtask
    task rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1 d = regRdData;
    endtask
    // gap in cycles between monitored pulses, 0 if they stop
    task automatic gap(output int r);
        int k;
        r = 0;
        for (int j = 0; j < 3; j++) begin
            k = 0;
            do begin
                @(posedge clk);
                #1 k++;
            end while (pulse !== 1'b1 && k < 1500);
            if (pulse !== 1'b1) begin
                r = 0;
                return;
            end
            r = k;
        end
    endtask
    task automatic count(input logic want, input int len, output int r);
        r = 0;
        repeat (len) begin
            @(posedge clk);
            #1 r += (detectEnable === want);
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            badCount++;
            stopTest();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            glitchOn <= rows[i].gl;
            wr(rows[i].a, rows[i].d);
            mon = rows[i].mon;
            if (rows[i].mon == 0) begin
                rd(rows[i].a, v);
                chkVal(v, rows[i].e[7:0]);
            end else begin
                gap(g);
                chkCnt(g, rows[i].e);
            end
            $display("row %0d done", i);
        end
        chkVal(slowOscTrim, 8'hC3);
        wr(9'h032, 8'h08);
        repeat (3) @(posedge clk);
        chkVal({5'h00, crystalOscEnable, sharedGpioOff, clockOutPinOeN}, 8'h07);
        wr(9'h032, 8'h00);
        repeat (3) @(posedge clk);
        chkVal({5'h00, crystalOscEnable, sharedGpioOff, clockOutPinOeN}, 8'h00);
        $display("crystal pins test done");
        sleepMode <= 1'b1;
        wr(9'h1E0, 8'h20);
        count(1'b0, 300, n);
        chkCnt(n, 0);
        chkVal({7'h00, slowOscNormalMode}, 8'h01);
        wr(9'h1E0, 8'h00);
        wr(9'h1E2, 8'h03);
        count(1'b1, 400, n);
        chkCnt(int'(n > 0 && n < 200), 1);
        chkVal({7'h00, slowOscNormalMode}, 8'h00);
        @(posedge clk);
        sleepMode <= 1'b0;
        $display("detector test done");
        wdtClear <= 1'b1;
        @(posedge clk);
        wdtClear <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (wdtExpire !== 1'b1 && n < 2500);
        chkCnt(int'(n > 1280 && n <= 1925), 1);
        $display("watchdog test done");
        @(posedge clk);
        nrst <= 1'b0;
        #1 chkVal({fastOscTrim[7:2], clockOutPinOeN, detectEnable}, 8'h13);
        chkVal(slowOscTrim, 8'h10);
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd(9'h031, v);
        chkVal(v, 8'h8F);
        rd(9'h030, v);
        chkVal(v, 8'h00);
        rd(9'h1E0, v);
        chkVal(v, 8'h00);
        rd(9'h034, v);
        chkVal(v, 8'h10);
        do begin
            u = v;
            rd(9'h1E3, v);
        end while (v !== u);
        chkVal(v & 8'h01, 8'h00);
        $display("reset test done");
        stopTest();
    end
endmodule
